// file: pkg/lpmc_pkg.sv
package lpmc_pkg;

   // ***************************************
   // Register map
   // ***************************************
   localparam int             APB_AW       = 8;
   localparam logic [APB_AW-1:0] CTRL_OFS  = 8'h00;
   localparam logic [APB_AW-1:0] IOCFG_OFS = 8'h04;
   localparam logic [APB_AW-1:0] STATUS_OFS = 8'h08;
   localparam logic [APB_AW-1:0] IRQ_STAT_OFS = 8'h0C;
   localparam logic [APB_AW-1:0] IRQ_MASK_OFS = 8'h10;

   // Control fields
   localparam int             CTRL_MODE_LSB    = 0;
   localparam int             CTRL_MODE_W      = 3;
   localparam int             CTRL_STOPCLK_BIT = 3;
   localparam int             CTRL_RTC_BIT     = 4;
   localparam int             CTRL_RET_BIT     = 5;
   localparam int             CTRL_POL_BIT     = 6;
   localparam int             CTRL_WKEN_BIT    = 7;
   localparam logic [31:0]    CTRL_RST         = 32'h0000_0010;
   localparam logic [31:0]    IOCFG_RST        = 32'h0000_0000;
   localparam logic [31:0]    MASK_RST         = 32'h0000_0000;

   // Low-power mode codes
   localparam logic [2:0]     MODE_STOP0    = 3'h0;
   localparam logic [2:0]     MODE_STOP1    = 3'h1;
   localparam logic [2:0]     MODE_STOP2    = 3'h2;
   localparam logic [2:0]     MODE_STANDBY  = 3'h3;
   localparam logic [2:0]     MODE_SHUTDOWN = 3'h4;

   // Status fields
   localparam int             STAT_MODE_LSB = 0;
   localparam int             STAT_LP_BIT   = 3;
   localparam int             STAT_SRC_LSB  = 4;
   localparam int             STAT_RSEQ_BIT = 10;

   // Interrupt bits
   localparam int             IRQ_W        = 4;
   localparam int             IRQ_STOP_WK  = 0;
   localparam int             IRQ_STBY_WK  = 1;
   localparam int             IRQ_SHDN_WK  = 2;
   localparam int             IRQ_ENTER    = 3;

   // Wake source bits
   localparam int             SRC_W      = 6;
   localparam int             SRC_EXTRST = 0;
   localparam int             SRC_WDOG   = 1;
   localparam int             SRC_PIN    = 2;
   localparam int             SRC_RTC    = 3;
   localparam int             SRC_LSEF   = 4;
   localparam int             SRC_PERIPH = 5;
   localparam logic [SRC_W-1:0] STOP_SRC_MASK = 6'h3F;
   localparam logic [SRC_W-1:0] STBY_SRC_MASK = 6'h1F;
   localparam logic [SRC_W-1:0] SHDN_SRC_MASK = 6'h0D;

   // System clock choice after wakeup
   localparam logic           SYSCLK_MULTI = 1'b0;
   localparam logic           SYSCLK_OSC16 = 1'b1;
   localparam logic [1:0]     MULTI_4MHZ   = 2'h0;
   localparam logic [1:0]     MULTI_8MHZ   = 2'h1;
   localparam logic [1:0]     MULTI_48MHZ  = 2'h2;

   // Standby pin states
   localparam logic [1:0]     IO_FLOAT    = 2'h0;
   localparam logic [1:0]     IO_PULLUP   = 2'h1;
   localparam logic [1:0]     IO_PULLDOWN = 2'h2;

   // ***************************************
   // Timing
   // ***************************************
   localparam int             CLK_PERIOD_PS   = 8000;
   localparam int             CORE_RST_HOLD_NS = 1000;
   localparam int             RST_HOLD_CYCLES =
      (CORE_RST_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   // ***************************************
   // Carriers
   // ***************************************
   typedef struct packed {
      logic main_reg_on;
      logic core_powered;
      logic core_low_leak;
      logic pll_on;
      logic multi_on;
      logic osc16_on;
      logic crystal_on;
      logic slow_rc_on;
      logic slow_crystal_on;
      logic rtc_on;
      logic brownout_on;
      logic vbat_switch_en;
      logic main_sram_on;
      logic ret_sram_on;
   } lpmc_pwr_type;

   typedef struct packed {
      logic       sel;
      logic [1:0] multi_range;
   } lpmc_clk_type;

endpackage

// file: verilog/lpmc_top.sv
`timescale 1ns/1ps
// How it works
// [RULE1] Three stop modes 0, 1, 2 with differing regulator and leakage settings.
// [RULE2] Stop 2 puts most of the core supply domain into low leakage.
// [RULE3] Stop 0 keeps the main regulator on for the fastest wakeup.
// [RULE4] In stop, a wakeup-capable peripheral may request the 16 MHz oscillator.
// [RULE5] Stop exit clock is multispeed at 48 MHz or 16 MHz oscillator, per software.
// [RULE6] Standby turns off regulator, core domain, PLL and fast oscillators.
// [RULE7] Standby keeps brownout reset on; RTC runs only if configured.
// [RULE8] Each pin takes software-chosen pull-up, pull-down or floating in standby.
// [RULE9] Standby drops main SRAM; retainable SRAM kept only when selected.
// [RULE10] Standby exits on reset pin, watchdog, wake pin, RTC or slow crystal failure.
// [RULE11] Standby wakeup runs from multispeed oscillator at 8 MHz.
// [RULE12] Shutdown turns off regulator, core, PLL and all oscillators but optional RTC.
// [RULE13] Shutdown has no brownout, no supply monitor, no backup supply switch.
// [RULE14] Shutdown drops both SRAMs and all non-backup registers.
// [RULE15] Shutdown exits only on reset pin, wake pin or RTC event.
// [RULE16] Shutdown wakeup runs from multispeed oscillator at exactly 4 MHz.
// [RULE17] Low-power entry happens when the processor executes its wait-for-event.
// [RULE18] Deep wakeups restart the core by a reset sequence; backup untouched.
module lpmc_top
   import lpmc_pkg::*;
#(
   parameter int NUM_IO = 8
) (
   // Clock and reset
   input  wire logic                clk_i,
   input  wire logic                rst_n_i,
   // APB slave
   input  wire logic                psel_i,
   input  wire logic                penable_i,
   input  wire logic                pwrite_i,
   input  wire logic [APB_AW-1:0]   paddr_i,
   input  wire logic [31:0]         pwdata_i,
   input  wire logic [3:0]          pstrb_i,
   output logic      [31:0]         prdata_o,
   output logic                     pready_o,
   output logic                     pslverr_o,
   // Processor and wake sources
   input  wire logic                wait_for_event_instr_i,
   input  wire logic                external_reset_pin_n_i,
   input  wire logic                independent_watchdog_rst_i,
   input  wire logic                wakeup_pin_i,
   input  wire logic [3:0]          rtc_event_i,
   input  wire logic                slow_crystal_fail_i,
   input  wire logic                periph_wake_i,
   input  wire logic                periph_hsi_req_i,
   // Power, clock and reset control
   output lpmc_pwr_type             pwr_o,
   output lpmc_clk_type             sysclk_o,
   output logic                     core_rst_n_o,
   output logic [2*NUM_IO-1:0]      io_pull_o,
   output logic                     io_standby_o,
   // Interrupt
   output logic                     irq_o
);

   // ***************************************
   // Declarations
   // ***************************************
   localparam int CNT_W = $clog2(RST_HOLD_CYCLES + 1);

   typedef enum logic [2:0] {S_RUN, S_STOP, S_STANDBY, S_SHUTDOWN, S_WAKE} lpmc_state_type;

   lpmc_state_type        state_ff;
   logic [2:0]            mode_ff;
   logic                  deep_ff;
   logic [CNT_W-1:0]      cnt_ff;
   logic [SRC_W-1:0]      src_ff;
   logic                  wpin_prev_ff;
   logic [31:0]           ctrl_ff;
   logic [31:0]           iocfg_ff;
   logic [IRQ_W-1:0]      stat_ff;
   logic [IRQ_W-1:0]      mask_ff;
   logic [31:0]           prdata_ff;
   lpmc_pwr_type          pwr_ff;
   lpmc_pwr_type          nxt_pwr;
   lpmc_clk_type          clk_ff;
   logic                  core_rst_n_ff;
   logic [2*NUM_IO-1:0]   io_pull_ff;
   logic                  io_stby_ff;

   logic                  wpin_edge;
   logic [SRC_W-1:0]      src_all;
   logic [SRC_W-1:0]      src_ok;
   logic                  wake;
   logic [2:0]            ctrl_mode;
   logic                  wr_en;
   logic                  rd_setup;
   logic                  addr_ok;
   logic [IRQ_W-1:0]      irq_set;
   logic [IRQ_W-1:0]      irq_clr;
   logic [31:0]           rd_mux;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] st);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (st[b]) begin
            r[8*b +: 8] = wd[8*b +: 8];
         end
      end
      return r;
   endfunction

   // ***************************************
   // Wake source qualification
   // ***************************************
   assign ctrl_mode = ctrl_ff[CTRL_MODE_LSB +: CTRL_MODE_W];

   // Pin is taken as synchronous; edge polarity is software selected
   assign wpin_edge = ctrl_ff[CTRL_WKEN_BIT] &
                      (ctrl_ff[CTRL_POL_BIT] ? (wpin_prev_ff & ~wakeup_pin_i) : (~wpin_prev_ff & wakeup_pin_i));

   always_comb begin
      src_all             = '0;
      src_all[SRC_EXTRST] = ~external_reset_pin_n_i;
      src_all[SRC_WDOG]   = independent_watchdog_rst_i;
      src_all[SRC_PIN]    = wpin_edge;
      // A stopped RTC cannot raise events
      src_all[SRC_RTC]    = ctrl_ff[CTRL_RTC_BIT] & (|rtc_event_i);
      src_all[SRC_LSEF]   = slow_crystal_fail_i;
      src_all[SRC_PERIPH] = periph_wake_i;
   end

   always_comb begin
      case (state_ff)
         S_STOP:     src_ok = src_all & STOP_SRC_MASK;
         S_STANDBY:  src_ok = src_all & STBY_SRC_MASK;   // [RULE10]
         S_SHUTDOWN: src_ok = src_all & SHDN_SRC_MASK;   // [RULE15]
         default:    src_ok = '0;
      endcase
   end

   assign wake = |src_ok;

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         wpin_prev_ff <= 1'b0;
      end else begin
         wpin_prev_ff <= wakeup_pin_i;
      end
   end

   // ***************************************
   // Mode sequencer
   // ***************************************
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         state_ff <= S_RUN;
         mode_ff  <= MODE_STOP0;
         deep_ff  <= 1'b0;
         cnt_ff   <= '0;
         src_ff   <= '0;
      end else begin
         case (state_ff)
            S_RUN: begin
               if (!external_reset_pin_n_i) begin
                  state_ff <= S_WAKE;
                  deep_ff  <= 1'b1;
                  cnt_ff   <= CNT_W'(RST_HOLD_CYCLES - 1);
               end else if (wait_for_event_instr_i) begin   // [RULE17]
                  mode_ff <= ctrl_mode;
                  case (ctrl_mode)
                     MODE_STOP0, MODE_STOP1, MODE_STOP2: state_ff <= S_STOP;   // [RULE1]
                     MODE_STANDBY:  state_ff <= S_STANDBY;
                     MODE_SHUTDOWN: state_ff <= S_SHUTDOWN;
                     default:       state_ff <= S_RUN;
                  endcase
               end
            end
            S_STOP, S_STANDBY, S_SHUTDOWN: begin
               if (wake) begin
                  state_ff <= S_WAKE;
                  src_ff   <= src_ok;
                  // Core state is gone after standby or shutdown, so restart it
                  deep_ff  <= (state_ff != S_STOP) | src_ok[SRC_EXTRST] | src_ok[SRC_WDOG];   // [RULE18]
                  cnt_ff   <= CNT_W'(RST_HOLD_CYCLES - 1);
               end
            end
            S_WAKE: begin
               if (!external_reset_pin_n_i && deep_ff) begin
                  cnt_ff <= CNT_W'(RST_HOLD_CYCLES - 1);
               end else if (!deep_ff || cnt_ff == '0) begin
                  state_ff <= S_RUN;
                  deep_ff  <= 1'b0;
               end else begin
                  cnt_ff <= cnt_ff - 1'b1;
               end
            end
            default: state_ff <= S_RUN;
         endcase
      end
   end

   // ***************************************
   // Wakeup clock selection
   // ***************************************
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         clk_ff <= '{sel: SYSCLK_MULTI, multi_range: MULTI_4MHZ};
      end else if (wake) begin
         case (state_ff)
            S_STOP: begin
               clk_ff.sel         <= ctrl_ff[CTRL_STOPCLK_BIT] ? SYSCLK_OSC16 : SYSCLK_MULTI;   // [RULE5]
               clk_ff.multi_range <= MULTI_48MHZ;
            end
            S_STANDBY: clk_ff <= '{sel: SYSCLK_MULTI, multi_range: MULTI_8MHZ};   // [RULE11]
            default:   clk_ff <= '{sel: SYSCLK_MULTI, multi_range: MULTI_4MHZ};   // [RULE16]
         endcase
      end
   end

   // ***************************************
   // Power domain control
   // ***************************************
   always_comb begin
      nxt_pwr = '1;
      case (state_ff)
         S_STOP: begin
            nxt_pwr.main_reg_on   = (mode_ff == MODE_STOP0);   // [RULE3]
            nxt_pwr.core_low_leak = (mode_ff == MODE_STOP2);   // [RULE2]
            nxt_pwr.pll_on        = 1'b0;
            nxt_pwr.multi_on      = 1'b0;
            nxt_pwr.crystal_on    = 1'b0;
            nxt_pwr.osc16_on      = periph_hsi_req_i;          // [RULE4]
            nxt_pwr.rtc_on        = ctrl_ff[CTRL_RTC_BIT];
         end
         S_STANDBY: begin
            nxt_pwr.main_reg_on   = 1'b0;                      // [RULE6]
            nxt_pwr.core_powered  = 1'b0;
            nxt_pwr.core_low_leak = 1'b0;
            nxt_pwr.pll_on        = 1'b0;
            nxt_pwr.multi_on      = 1'b0;
            nxt_pwr.osc16_on      = 1'b0;
            nxt_pwr.crystal_on    = 1'b0;
            nxt_pwr.rtc_on        = ctrl_ff[CTRL_RTC_BIT];     // [RULE7]
            nxt_pwr.brownout_on   = 1'b1;                      // [RULE7]
            nxt_pwr.main_sram_on  = 1'b0;                      // [RULE9]
            nxt_pwr.ret_sram_on   = ctrl_ff[CTRL_RET_BIT];     // [RULE9]
         end
         S_SHUTDOWN: begin
            nxt_pwr               = '0;                        // [RULE12] [RULE14]
            nxt_pwr.rtc_on        = ctrl_ff[CTRL_RTC_BIT];
            // The RTC needs its crystal when it is kept running
            nxt_pwr.slow_crystal_on = ctrl_ff[CTRL_RTC_BIT];
            nxt_pwr.brownout_on   = 1'b0;                      // [RULE13]
            nxt_pwr.vbat_switch_en = 1'b0;                     // [RULE13]
         end
         default: begin
            nxt_pwr.core_low_leak = 1'b0;
            nxt_pwr.rtc_on        = ctrl_ff[CTRL_RTC_BIT];
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         pwr_ff <= '0;
      end else begin
         pwr_ff <= nxt_pwr;
      end
   end

   // Only the core is reset here; backup domain has no reset from this block
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         core_rst_n_ff <= 1'b0;
      end else begin
         core_rst_n_ff <= ~((state_ff == S_STANDBY) | (state_ff == S_SHUTDOWN) |
                            ((state_ff == S_WAKE) & deep_ff));   // [RULE18]
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         io_pull_ff <= '0;
         io_stby_ff <= 1'b0;
      end else begin
         io_stby_ff <= (state_ff == S_STANDBY);
         io_pull_ff <= (state_ff == S_STANDBY) ? iocfg_ff[2*NUM_IO-1:0] : '0;   // [RULE8]
      end
   end

   // ***************************************
   // APB registers
   // ***************************************
   assign wr_en    = psel_i & penable_i & pwrite_i & addr_ok;
   assign rd_setup = psel_i & ~penable_i & ~pwrite_i;
   assign addr_ok  = (paddr_i == CTRL_OFS) | (paddr_i == IOCFG_OFS) | (paddr_i == STATUS_OFS) |
                     (paddr_i == IRQ_STAT_OFS) | (paddr_i == IRQ_MASK_OFS);

   always_comb begin
      rd_mux = '0;
      case (paddr_i)
         CTRL_OFS:     rd_mux = ctrl_ff;
         IOCFG_OFS:    rd_mux = iocfg_ff;
         STATUS_OFS: begin
            rd_mux[STAT_MODE_LSB +: 3]     = mode_ff;
            rd_mux[STAT_LP_BIT]            = (state_ff != S_RUN);
            rd_mux[STAT_SRC_LSB +: SRC_W]  = src_ff;
            rd_mux[STAT_RSEQ_BIT]          = ~core_rst_n_ff;
         end
         IRQ_STAT_OFS: rd_mux[IRQ_W-1:0] = stat_ff;
         IRQ_MASK_OFS: rd_mux[IRQ_W-1:0] = mask_ff;
         default:      rd_mux = '0;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         prdata_ff <= '0;
      end else if (rd_setup) begin
         prdata_ff <= rd_mux;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         ctrl_ff  <= CTRL_RST;
         iocfg_ff <= IOCFG_RST;
         mask_ff  <= MASK_RST[IRQ_W-1:0];
      end else if (wr_en) begin
         if (paddr_i == CTRL_OFS) begin
            ctrl_ff <= merge(ctrl_ff, pwdata_i, pstrb_i);
         end
         if (paddr_i == IOCFG_OFS) begin
            iocfg_ff <= merge(iocfg_ff, pwdata_i, pstrb_i);
         end
         if (paddr_i == IRQ_MASK_OFS && pstrb_i[0]) begin
            mask_ff <= pwdata_i[IRQ_W-1:0];
         end
      end
   end

   // ***************************************
   // Interrupts
   // ***************************************
   always_comb begin
      irq_set              = '0;
      irq_set[IRQ_STOP_WK] = wake & (state_ff == S_STOP);
      irq_set[IRQ_STBY_WK] = wake & (state_ff == S_STANDBY);
      irq_set[IRQ_SHDN_WK] = wake & (state_ff == S_SHUTDOWN);
      irq_set[IRQ_ENTER]   = (state_ff == S_RUN) & wait_for_event_instr_i & external_reset_pin_n_i;
   end

   assign irq_clr = (wr_en && paddr_i == IRQ_STAT_OFS && pstrb_i[0]) ? pwdata_i[IRQ_W-1:0] : '0;

   // A new event in the clearing cycle is kept
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         stat_ff <= '0;
      end else begin
         stat_ff <= (stat_ff & ~irq_clr) | irq_set;
      end
   end

   // ***************************************
   // Outputs
   // ***************************************
   assign prdata_o     = prdata_ff;
   assign pready_o     = 1'b1;
   assign pslverr_o    = psel_i & penable_i & ~addr_ok;
   assign pwr_o        = pwr_ff;
   assign sysclk_o     = clk_ff;
   assign core_rst_n_o = core_rst_n_ff;
   assign io_pull_o    = io_pull_ff;
   assign io_standby_o = io_stby_ff;
   assign irq_o        = |(stat_ff & mask_ff);

   // ***************************************
   // Checks
   // ***************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   chk_stop0_mainreg: assert property (state_ff == S_STOP && mode_ff == MODE_STOP0 |=> pwr_o.main_reg_on) // [RULE3]
      else $error("Main regulator off in stop 0");
   chk_stop2_leak: assert property (state_ff == S_STOP && mode_ff == MODE_STOP2 |=> pwr_o.core_low_leak) // [RULE2]
      else $error("Low leakage missing in stop 2");
   chk_stop_hsi_req: assert property (state_ff == S_STOP && periph_hsi_req_i |=> pwr_o.osc16_on) // [RULE4]
      else $error("Peripheral oscillator request ignored");
   chk_standby_off: assert property (state_ff == S_STANDBY |=> !pwr_o.main_reg_on && !pwr_o.pll_on &&
      !pwr_o.multi_on && !pwr_o.osc16_on && !pwr_o.crystal_on && pwr_o.brownout_on) // [RULE6]
      else $error("Standby power state wrong");
   chk_shdn_nobor: assert property (state_ff == S_SHUTDOWN |=> !pwr_o.brownout_on && !pwr_o.vbat_switch_en
      && !pwr_o.slow_rc_on && !pwr_o.ret_sram_on) // [RULE13]
      else $error("Shutdown power state wrong");
   chk_shdn_wake_src: assert property (state_ff == S_SHUTDOWN && (src_all & SHDN_SRC_MASK) == '0
      |=> state_ff == S_SHUTDOWN) // [RULE15]
      else $error("Shutdown left on illegal source");
   chk_stby_wake_clk: assert property (state_ff == S_STANDBY && wake
      |=> sysclk_o.sel == SYSCLK_MULTI && sysclk_o.multi_range == MULTI_8MHZ) // [RULE11]
      else $error("Standby wake clock wrong");
   chk_shdn_wake_clk: assert property (state_ff == S_SHUTDOWN && wake
      |=> sysclk_o.sel == SYSCLK_MULTI && sysclk_o.multi_range == MULTI_4MHZ) // [RULE16]
      else $error("Shutdown wake clock wrong");
   chk_stop_wake_clk: assert property (state_ff == S_STOP && wake
      |=> sysclk_o.sel == $past(ctrl_ff[CTRL_STOPCLK_BIT])) // [RULE5]
      else $error("Stop wake clock wrong");
   chk_wfe_entry: assert property (state_ff == S_RUN && wait_for_event_instr_i && external_reset_pin_n_i &&
      ctrl_mode == MODE_STANDBY |=> state_ff == S_STANDBY ##2 io_standby_o) // [RULE17]
      else $error("Standby not entered on wait-for-event");
   chk_rst_seq: assert property (state_ff == S_STANDBY && wake |=> ##1 !core_rst_n_o [*8]) // [RULE18]
      else $error("Core reset sequence too short");

   cov_stop_wake: cover property (state_ff == S_STOP && wake);
   cov_stby_wake: cover property (state_ff == S_STANDBY && wake ##[1:200] state_ff == S_RUN);
   cov_shdn_wake: cover property (state_ff == S_SHUTDOWN && wake);

endmodule

// file: test/lpmc_wake_src.sv
`timescale 1ns/1ps
// ****************
// Wake source model
// ****************
module lpmc_wake_src (
   // Clock and commands
   input  wire logic       clk_i,
   input  wire logic       pin_go_i,
   input  wire logic       external_reset_pin_go_i,
   input  wire logic       rtc_go_i,
   // Wake lines
   output logic            wakeup_pin_o = 1'b0,
   output logic            external_reset_pin_n_o = 1'b1,
   output logic [3:0]      rtc_event_o = 4'h0
);
   // Levels move only after an edge, like a real pin seen through a synchroniser
   always @(posedge clk_i) begin
      wakeup_pin_o           <= pin_go_i;
      external_reset_pin_n_o <= ~external_reset_pin_go_i;
      rtc_event_o            <= {3'h0, rtc_go_i};
   end
endmodule

// file: test/lpmc_top_tb.sv
`timescale 1ns/1ps
// ****************
// Bench
// ****************
module lpmc_top_tb;
   import lpmc_pkg::*;
   logic         clk_i = 1'b0;
   logic         rst_n_i, psel_i, penable_i, pwrite_i, wait_for_event_instr, wdg, lsef, pwk, phsi, pin_go, external_reset_pin_go, rtc_go;
   logic [7:0]   paddr_i;
   logic [31:0]  pwdata_i, prdata_o, rd;
   logic         pready_o, pslverr_o, er, core_rst_n_o, io_standby_o, irq_o, wpin, xrst_n;
   logic [3:0]   rtc_ev;
   logic [15:0]  io_pull_o;
   lpmc_pwr_type pwr_o;
   lpmc_clk_type sysclk_o;
   int           n_mismatch, check_count;

   always #4 clk_i = ~clk_i;

   lpmc_top #(.NUM_IO(8)) i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(4'hF), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .wait_for_event_instr_i(wait_for_event_instr),
      .external_reset_pin_n_i(xrst_n), .independent_watchdog_rst_i(wdg), .wakeup_pin_i(wpin),
      .rtc_event_i(rtc_ev), .slow_crystal_fail_i(lsef), .periph_wake_i(pwk), .periph_hsi_req_i(phsi),
      .pwr_o(pwr_o), .sysclk_o(sysclk_o), .core_rst_n_o(core_rst_n_o), .io_pull_o(io_pull_o),
      .io_standby_o(io_standby_o), .irq_o(irq_o));

   lpmc_wake_src i_src (.clk_i(clk_i), .pin_go_i(pin_go), .external_reset_pin_go_i(external_reset_pin_go), .rtc_go_i(rtc_go),
      .wakeup_pin_o(wpin), .external_reset_pin_n_o(xrst_n), .rtc_event_o(rtc_ev));

   // ****************
   // Shared tasks
   // ****************
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      psel_i    <= 1'b1;
      pwrite_i  <= w;
      paddr_i   <= a;
      pwdata_i  <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      @(posedge clk_i);
      while (pready_o !== 1'b1) @(posedge clk_i);
      rd = prdata_o;
      er = pslverr_o;
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
   endtask

   task automatic enter(input logic [31:0] c);
      apb(1'b1, CTRL_OFS, c);
      @(posedge clk_i);
      wait_for_event_instr <= 1'b1;
      @(posedge clk_i);
      wait_for_event_instr <= 1'b0;
      repeat (3) @(posedge clk_i);
      #1;
   endtask

   // Core reset must stay low for at least RST_HOLD_CYCLES - 8 cycles from the call, then the core comes back powered
   task automatic wait_run();
      int k;
      k = 0;
      while (core_rst_n_o !== 1'b1 && k < 400) begin
         @(posedge clk_i);
         k++;
      end
      repeat (2) @(posedge clk_i);
      #1;
      chk("rst_hold", 1, k >= RST_HOLD_CYCLES - 8 && k < 400);
      chk("run_core", 1, pwr_o.core_powered);
   endtask

   // ****************
   // Scenarios
   // ****************
   task automatic t_reset();
      chk("pwr_run", 14'h37FF, pwr_o);
      apb(1'b0, CTRL_OFS, 32'h0);
      chk("ctrl_rst", CTRL_RST, rd);
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped_err", 1, er);
      chk("unmapped_rd", 0, rd);
   endtask

   task automatic t_stop();
      apb(1'b1, IRQ_MASK_OFS, 32'h0000_0001);
      for (int m = 0; m < 3; m++) begin
         @(posedge clk_i);
         phsi <= (m != 1);
         enter(32'(m + (m == 1) * 8));
         chk("stop_reg", m == 0, pwr_o.main_reg_on);
         chk("stop_leak", m == 2, pwr_o.core_low_leak);
         chk("stop_hsi", m != 1, pwr_o.osc16_on);
         chk("irq_masked", 0, irq_o);
         @(posedge clk_i);
         pwk <= 1'b1;
         @(posedge clk_i);
         pwk <= 1'b0;
         repeat (3) @(posedge clk_i);
         #1;
         chk("stop_sel", m == 1, sysclk_o.sel);
         if (m != 1) chk("stop_range", MULTI_48MHZ, sysclk_o.multi_range);
         chk("stop_core", 1, core_rst_n_o);
         chk("irq_set", 1, irq_o);
         apb(1'b1, IRQ_STAT_OFS, 32'h0000_000F);
         #1;
         chk("irq_clr", 0, irq_o);
      end
   endtask

   task automatic t_standby();
      apb(1'b1, IOCFG_OFS, 32'h0000_0009);
      enter(32'h0000_00B3);
      chk("stby_pwr", 8'h00, {pwr_o.main_reg_on, pwr_o.core_powered, pwr_o.pll_on, pwr_o.multi_on,
         pwr_o.osc16_on, pwr_o.crystal_on, pwr_o.main_sram_on});
      chk("stby_keep", 3'h7, {pwr_o.brownout_on, pwr_o.rtc_on, pwr_o.ret_sram_on});
      chk("stby_io", 16'h0009, io_pull_o);
      chk("stby_flag", 1, io_standby_o);
      chk("stby_rst", 0, core_rst_n_o);
      @(posedge clk_i);
      pwk <= 1'b1;
      @(posedge clk_i);
      pwk <= 1'b0;
      pin_go <= 1'b1;
      repeat (4) @(posedge clk_i);
      #1;
      chk("stby_clk", {SYSCLK_MULTI, MULTI_8MHZ}, sysclk_o);
      @(posedge clk_i);
      pin_go <= 1'b0;
      wait_run();
      apb(1'b0, CTRL_OFS, 32'h0);
      chk("ctrl_kept", 32'h0000_00B3, rd);
      apb(1'b0, IRQ_STAT_OFS, 32'h0);
      chk("stby_stat", 4'hA, rd[3:0]);
   endtask

   task automatic t_shutdown();
      // Falling-edge polarity: the rising pin edge below must not wake the block
      enter(32'h0000_00C4);
      chk("shdn_pwr", 12'h000, {pwr_o.main_reg_on, pwr_o.core_powered, pwr_o.pll_on, pwr_o.multi_on,
         pwr_o.osc16_on, pwr_o.crystal_on, pwr_o.slow_rc_on, pwr_o.rtc_on, pwr_o.main_sram_on,
         pwr_o.ret_sram_on});
      chk("shdn_mon", 2'h0, {pwr_o.brownout_on, pwr_o.vbat_switch_en});
      @(posedge clk_i);
      wdg <= 1'b1;
      lsef <= 1'b1;
      rtc_go <= 1'b1;
      pin_go <= 1'b1;
      repeat (4) @(posedge clk_i);
      wdg <= 1'b0;
      lsef <= 1'b0;
      rtc_go <= 1'b0;
      #1;
      chk("shdn_stay", 0, pwr_o.core_powered);
      @(posedge clk_i);
      external_reset_pin_go <= 1'b1;
      repeat (3) @(posedge clk_i);
      external_reset_pin_go <= 1'b0;
      pin_go <= 1'b0;
      #1;
      chk("shdn_clk", {SYSCLK_MULTI, MULTI_4MHZ}, sysclk_o);
      wait_run();
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   initial begin
      {rst_n_i, psel_i, penable_i, pwrite_i, wait_for_event_instr, wdg, lsef, pwk, phsi, pin_go, external_reset_pin_go, rtc_go} = '0;
      paddr_i = '0;
      pwdata_i = '0;
      n_mismatch = 0;
      check_count = 0;
      repeat (3) @(posedge clk_i);
      rst_n_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      #1;
      t_reset();
      t_stop();
      t_standby();
      t_shutdown();
      conclude();
   end

   initial begin
      #200000;
      n_mismatch++;
      conclude();
   end
endmodule
